// [hdl/dsr_pkg.sv]
// constants, types and state layout for the rundown sequencer
// Functional notes
// - Current sets run coarse neg, coarse pos, mid neg, fine pos, finest neg; nulls between.
// - Coarse half-ramps last ten strobe cycles each.
// - Rundown holds five consecutive periods, one per current set, finest last.
// - Comparator level at rundown start gives residual polarity: high positive.
// - Negative residual: coarse negative half-ramps until crossing, at most three.
// - Coarse and mid currents drop within ten strobe cycles of crossing.
// - A set finishing early leaves null slope for the rest of its period.
// - Positive residual: brief coarse negative pulse, then null for period one.
// - Period two: coarse positive ramps until crossing, at most three, same length.
// - Period three: mid negative ramps until crossing, at most seven, then null.
// - Period four, as long as three: fine positive ramps, at most seven.
// - After finest negative crosses, finest positive quarter ramps of five cycles run.
// - Finest negative and positive alternate, each to its crossing, until period five ends.
// - Slopes of each of the five sets are counted for digit computation, the finest negative only until its first crossing.
// - Offset DAC is enabled before the fine positive set starts.
// - Dithering compares positive and negative run lengths and steps the DAC.
// - Five control lines carry the slope command, changing on strobe boundaries.
// - Function select routes DC or AC converter output to the integrator.
package dsr_pkg;
  localparam int HALF_TICKS = 10;
  localparam int QUARTER_TICKS = 5;
  localparam int SHORT_TICKS = 2;
  localparam int COARSE_MAX = 3;
  localparam int MID_MAX = 7;
  localparam int FINE_TICKS = 120;
  localparam int DAC_W = 8;
  localparam logic [7:0] DAC_MID = 8'h80;
  localparam logic [7:0] DAC_TOP = 8'hFF;
  // five-line slope commands
  localparam logic [4:0] CODE_M4 = 5'h01;
  localparam logic [4:0] CODE_P4 = 5'h02;
  localparam logic [4:0] CODE_M3 = 5'h03;
  localparam logic [4:0] CODE_P2 = 5'h04;
  localparam logic [4:0] CODE_M1 = 5'h05;
  localparam logic [4:0] CODE_P1 = 5'h06;
  localparam logic [4:0] CODE_M0 = 5'h07;
  localparam logic [4:0] CODE_P0 = 5'h08;
  typedef enum logic [2:0] {DSR_IDLE, DSR_P1, DSR_P2, DSR_P3, DSR_P4, DSR_P5} dsr_phase_t;
  typedef struct packed {
    logic [2:0] m4;
    logic [2:0] p4;
    logic [2:0] m3;
    logic [2:0] p2;
    logic [7:0] m1;
  } dsr_counts_t;
  typedef struct packed {
    logic strobe_s1;
    logic strobe_s2;
    logic strobe_s3;
    logic cmp_s1;
    logic cmp_s2;
    logic pending;
    dsr_phase_t phase;
    logic active;
    logic crossed;
    logic ref_lvl;
    logic pos_res;
    logic in_pos;
    logic first;
    logic [3:0] rtick;
    logic [2:0] rnum;
    logic [7:0] ptick;
    logic [7:0] run_len;
    logic [7:0] neg_len;
    logic [7:0] dac;
    logic dac_en;
    logic [4:0] sel;
    logic route;
    logic busy;
    logic done;
    dsr_counts_t counts;
  } dsr_state_t;
endpackage

// [hdl/dsr_sequencer.sv]
// rundown sequencer for a multislope integrating converter
`timescale 1ns/10ps
module dsr_sequencer #(
  parameter int FINE_TICKS = dsr_pkg::FINE_TICKS,
  parameter int COARSE_MAX = dsr_pkg::COARSE_MAX,
  parameter int MID_MAX = dsr_pkg::MID_MAX
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic strobe_i,
  input wire logic comparator_out_i,
  input wire logic start_i,
  input wire logic func_ac_i,
  output logic [4:0] ctrl_lines_o,
  output logic input_route_o,
  output logic dac_en_o,
  output logic [7:0] dac_code_o,
  output dsr_pkg::dsr_counts_t counts_o,
  output logic positive_o,
  output logic busy_o,
  output logic done_o
);
  dsr_pkg::dsr_state_t s_reg;
  dsr_pkg::dsr_state_t s_next;
  logic tick;
  logic cmp;
  logic cross_now;
  logic [3:0] ramp_len;
  logic [7:0] per_len;
  logic [7:0] run_end;

  // strobe edge marks one converter clock; comparator read only from second stage
  assign tick = s_reg.strobe_s2 & ~s_reg.strobe_s3;
  assign cmp = s_reg.cmp_s2;
  assign cross_now = s_reg.crossed | (cmp != s_reg.ref_lvl);
  assign run_end = s_reg.run_len + 8'h01;

  // ramp and period lengths for the current phase
  always_comb begin
    if (s_reg.phase == dsr_pkg::DSR_P1 && s_reg.pos_res) begin
      ramp_len = 4'(dsr_pkg::SHORT_TICKS);
    end else if (s_reg.phase == dsr_pkg::DSR_P5 && s_reg.in_pos) begin
      ramp_len = 4'(dsr_pkg::QUARTER_TICKS);
    end else begin
      ramp_len = 4'(dsr_pkg::HALF_TICKS);
    end
    unique case (s_reg.phase)
      dsr_pkg::DSR_P1, dsr_pkg::DSR_P2: per_len = 8'(COARSE_MAX * dsr_pkg::HALF_TICKS);
      dsr_pkg::DSR_P3, dsr_pkg::DSR_P4: per_len = 8'(MID_MAX * dsr_pkg::HALF_TICKS);
      default: per_len = 8'(FINE_TICKS);
    endcase
  end

  // next state of the whole sequencer
  always_comb begin
    s_next = s_reg;
    s_next.strobe_s1 = strobe_i;
    s_next.strobe_s2 = s_reg.strobe_s1;
    s_next.strobe_s3 = s_reg.strobe_s2;
    s_next.cmp_s1 = comparator_out_i;
    s_next.cmp_s2 = s_reg.cmp_s1;
    if (start_i) begin
      s_next.pending = 1'b1;
    end
    if (tick) begin
      s_next.route = func_ac_i;
      if (s_reg.phase == dsr_pkg::DSR_IDLE) begin
        if (s_reg.pending) begin
          // a start arriving on the starting cycle itself is kept, not lost
          s_next.pending = start_i;
          s_next.phase = dsr_pkg::DSR_P1;
          s_next.busy = 1'b1;
          s_next.done = 1'b0;
          s_next.pos_res = cmp;
          s_next.ref_lvl = cmp;
          s_next.active = 1'b1;
          s_next.crossed = 1'b0;
          s_next.rtick = 4'h0;
          s_next.rnum = 3'h0;
          s_next.ptick = 8'h00;
          s_next.run_len = 8'h00;
          s_next.in_pos = 1'b0;
          s_next.counts = '0;
          s_next.dac_en = 1'b0;
          s_next.sel = dsr_pkg::CODE_M4;
        end
      end else begin
        s_next.ptick = s_reg.ptick + 8'h01;
        if (s_reg.active) begin
          s_next.rtick = s_reg.rtick + 4'h1;
          s_next.run_len = run_end;
          if (cmp != s_reg.ref_lvl) begin
            s_next.crossed = 1'b1;
          end
          if (s_next.rtick == ramp_len) begin
            s_next.rtick = 4'h0;
            if (s_reg.phase == dsr_pkg::DSR_P5) begin
              if (!s_reg.in_pos && s_reg.first) begin
                s_next.counts.m1 = s_reg.counts.m1 + 8'h01;
              end
              if (cross_now) begin
                // swap sign of the finest current at each crossing
                s_next.in_pos = ~s_reg.in_pos;
                s_next.ref_lvl = cmp;
                s_next.crossed = 1'b0;
                s_next.run_len = 8'h00;
                s_next.sel = s_reg.in_pos ? dsr_pkg::CODE_M1 : dsr_pkg::CODE_P1;
                if (!s_reg.in_pos) begin
                  s_next.neg_len = run_end;
                  s_next.first = 1'b0;
                end else if (s_reg.neg_len > run_end && s_reg.dac != dsr_pkg::DAC_TOP) begin
                  s_next.dac = s_reg.dac + 8'h01;
                end else if (s_reg.neg_len < run_end && s_reg.dac != 8'h00) begin
                  s_next.dac = s_reg.dac - 8'h01;
                end
              end
            end else begin
              s_next.rnum = s_reg.rnum + 3'h1;
              unique case (s_reg.phase)
                dsr_pkg::DSR_P1: s_next.counts.m4 = s_reg.counts.m4 + 3'h1;
                dsr_pkg::DSR_P2: s_next.counts.p4 = s_reg.counts.p4 + 3'h1;
                dsr_pkg::DSR_P3: s_next.counts.m3 = s_reg.counts.m3 + 3'h1;
                default: s_next.counts.p2 = s_reg.counts.p2 + 3'h1;
              endcase
              // drop the current at ramp end once crossed or at the limit
              if (cross_now || (s_reg.phase == dsr_pkg::DSR_P1 && s_reg.pos_res)
                  || s_next.rnum == 3'(s_reg.phase <= dsr_pkg::DSR_P2 ? COARSE_MAX : MID_MAX)) begin
                s_next.active = 1'b0;
                s_next.sel = dsr_pkg::CODE_M0;
              end
            end
          end
        end
        // period boundary: advance to the next current set, or back to idle after period five
        if (s_next.ptick == per_len) begin
          s_next.ptick = 8'h00;
          s_next.rtick = 4'h0;
          s_next.rnum = 3'h0;
          s_next.active = 1'b1;
          s_next.crossed = 1'b0;
          s_next.ref_lvl = cmp;
          s_next.run_len = 8'h00;
          s_next.in_pos = 1'b0;
          unique case (s_reg.phase)
            dsr_pkg::DSR_P1: begin
              s_next.phase = dsr_pkg::DSR_P2;
              s_next.sel = dsr_pkg::CODE_P4;
            end
            dsr_pkg::DSR_P2: begin
              s_next.phase = dsr_pkg::DSR_P3;
              s_next.sel = dsr_pkg::CODE_M3;
              s_next.dac_en = 1'b1;
            end
            dsr_pkg::DSR_P3: begin
              s_next.phase = dsr_pkg::DSR_P4;
              s_next.sel = dsr_pkg::CODE_P2;
            end
            dsr_pkg::DSR_P4: begin
              s_next.phase = dsr_pkg::DSR_P5;
              s_next.sel = dsr_pkg::CODE_M1;
              s_next.first = 1'b1;
            end
            default: begin
              s_next.phase = dsr_pkg::DSR_IDLE;
              s_next.sel = dsr_pkg::CODE_P0;
              s_next.active = 1'b0;
              s_next.busy = 1'b0;
              s_next.done = 1'b1;
            end
          endcase
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
      s_reg.dac <= dsr_pkg::DAC_MID;
      s_reg.sel <= dsr_pkg::CODE_P0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign ctrl_lines_o = s_reg.sel;
  assign input_route_o = s_reg.route;
  assign dac_en_o = s_reg.dac_en;
  assign dac_code_o = s_reg.dac;
  assign counts_o = s_reg.counts;
  assign positive_o = s_reg.pos_res;
  assign busy_o = s_reg.busy;
  assign done_o = s_reg.done;

  // checks on the sequence
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_order;
    (s_reg.phase == dsr_pkg::DSR_P2 && $past(s_reg.phase) != dsr_pkg::DSR_P2) |-> $past(s_reg.phase) == dsr_pkg::DSR_P1;
  endproperty
  a_order: assert property (p_order) else $error("period two not entered from period one");

  property p_half;
    s_reg.active && !s_reg.pos_res && s_reg.phase == dsr_pkg::DSR_P1 |-> s_reg.rtick < 4'(dsr_pkg::HALF_TICKS);
  endproperty
  a_half: assert property (p_half) else $error("half-ramp overran");

  property p_coarse_max;
    s_reg.phase inside {dsr_pkg::DSR_P1, dsr_pkg::DSR_P2} |-> s_reg.rnum <= 3'(COARSE_MAX);
  endproperty
  a_coarse_max: assert property (p_coarse_max) else $error("too many coarse ramps");

  property p_mid_max;
    s_reg.phase == dsr_pkg::DSR_P3 && s_reg.rnum == 3'(MID_MAX) |-> !s_reg.active;
  endproperty
  a_mid_max: assert property (p_mid_max) else $error("too many mid ramps");

  property p_remove;
    tick && s_reg.active && cross_now && s_reg.phase != dsr_pkg::DSR_P5 && s_reg.phase != dsr_pkg::DSR_IDLE
      && s_reg.rtick + 4'h1 == ramp_len && s_reg.ptick + 8'h01 != per_len |=> !s_reg.active && s_reg.sel == dsr_pkg::CODE_M0;
  endproperty
  a_remove: assert property (p_remove) else $error("current not removed after crossing");

  property p_null;
    !s_reg.active && s_reg.phase != dsr_pkg::DSR_IDLE |-> s_reg.sel == dsr_pkg::CODE_M0;
  endproperty
  a_null: assert property (p_null) else $error("idle current not null");

  property p_polarity;
    tick && s_reg.phase == dsr_pkg::DSR_IDLE && s_reg.pending |=> s_reg.pos_res == $past(cmp) && s_reg.sel == dsr_pkg::CODE_M4;
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity not taken at start");

  property p_short;
    s_reg.phase == dsr_pkg::DSR_P1 && s_reg.pos_res && s_reg.active |-> s_reg.rtick < 4'(dsr_pkg::SHORT_TICKS);
  endproperty
  a_short: assert property (p_short) else $error("positive residual pulse too long");

  property p_quarter;
    s_reg.phase == dsr_pkg::DSR_P5 && s_reg.in_pos |-> s_reg.rtick < 4'(dsr_pkg::QUARTER_TICKS);
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter ramp overran");

  property p_dac;
    s_reg.phase inside {dsr_pkg::DSR_P4, dsr_pkg::DSR_P5} |-> s_reg.dac_en;
  endproperty
  a_dac: assert property (p_dac) else $error("offset dac off during fine sets");

  property p_sync_sel;
    !tick |=> $stable(s_reg.sel);
  endproperty
  a_sync_sel: assert property (p_sync_sel) else $error("slope changed off a strobe");

  property p_period_len;
    s_reg.phase != dsr_pkg::DSR_IDLE |-> s_reg.ptick < per_len;
  endproperty
  a_period_len: assert property (p_period_len) else $error("period overran its length");

  property p_coarse_stop;
    s_reg.phase inside {dsr_pkg::DSR_P1, dsr_pkg::DSR_P2} && s_reg.rnum == 3'(COARSE_MAX) |-> !s_reg.active;
  endproperty
  a_coarse_stop: assert property (p_coarse_stop) else $error("coarse current kept past its limit");

  property p_fine_stop;
    s_reg.phase == dsr_pkg::DSR_P4 && s_reg.rnum == 3'(MID_MAX) |-> !s_reg.active;
  endproperty
  a_fine_stop: assert property (p_fine_stop) else $error("fine current kept past its limit");

  property p_alternate;
    tick && s_reg.phase == dsr_pkg::DSR_P5 && s_reg.active && cross_now && s_reg.rtick + 4'h1 == ramp_len
      && s_reg.ptick + 8'h01 != per_len |=> s_reg.in_pos != $past(s_reg.in_pos);
  endproperty
  a_alternate: assert property (p_alternate) else $error("finest current sign not swapped");

  property p_dac_step;
    s_reg.dac != $past(s_reg.dac) |-> $past(s_reg.phase) == dsr_pkg::DSR_P5 && $past(s_reg.in_pos);
  endproperty
  a_dac_step: assert property (p_dac_step) else $error("dac moved outside a positive fine run");

  property p_route;
    tick |=> s_reg.route == $past(func_ac_i);
  endproperty
  a_route: assert property (p_route) else $error("input route not taken on a strobe");

  property p_count_step;
    s_reg.counts.m4 != $past(s_reg.counts.m4) && $past(s_reg.phase) != dsr_pkg::DSR_IDLE
      |-> s_reg.counts.m4 == $past(s_reg.counts.m4) + 3'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("coarse count jumped");

  property p_busy_done;
    s_reg.done |-> !s_reg.busy;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("done while still busy");

  property p_fine_order;
    s_reg.phase == dsr_pkg::DSR_P5 && $past(s_reg.phase) != dsr_pkg::DSR_P5
      |-> $past(s_reg.phase) == dsr_pkg::DSR_P4 && s_reg.sel == dsr_pkg::CODE_M1 && s_reg.dac_en;
  endproperty
  a_fine_order: assert property (p_fine_order) else $error("finest set not entered from period four");

  c_done: cover property (s_reg.busy ##1 s_reg.done);
  c_flip: cover property (s_reg.phase == dsr_pkg::DSR_P5 && s_reg.in_pos);
  c_dac_step: cover property (s_reg.phase == dsr_pkg::DSR_P5 && $changed(s_reg.dac));
  c_pos_res: cover property (s_reg.phase == dsr_pkg::DSR_P2 && s_reg.pos_res);
  c_coarse_limit: cover property (s_reg.phase == dsr_pkg::DSR_P2 && s_reg.counts.m4 == 3'(COARSE_MAX));
endmodule // dsr_sequencer

// [dv/dsr_hybrid_model.sv]
// behavioural converter hybrid: integrator and latched comparator
`timescale 1ns/10ps
module dsr_hybrid_model (
  input wire logic strobe_i,
  input wire logic [4:0] ctrl_lines_i,
  input wire logic dac_en_i,
  input wire logic [7:0] dac_code_i,
  input wire logic load_i,
  input wire logic signed [31:0] residual_i,
  output logic comparator_o
);
  int level = 0;
  int rate;
  initial comparator_o = 1'b0;
  // decode the five control lines into a slope per tick
  always_comb begin
    case (ctrl_lines_i)
      dsr_pkg::CODE_M4: rate = 1000;
      dsr_pkg::CODE_P4: rate = -1000;
      dsr_pkg::CODE_M3: rate = 100;
      dsr_pkg::CODE_P2: rate = -10;
      dsr_pkg::CODE_M1: rate = 1;
      dsr_pkg::CODE_P1: rate = -1;
      default: rate = 0;
    endcase
  end
  // latch the comparator on each strobe, then integrate the selected slope
  always @(posedge strobe_i or posedge load_i) begin
    if (load_i) begin
      level <= residual_i;
    end else begin
      comparator_o <= (level >= 0);
      level <= level + rate + (dac_en_i ? int'(dac_code_i) - 128 : 0);
    end
  end
endmodule // dsr_hybrid_model

// [dv/tb_top.sv]
// self-checking bench for the rundown sequencer against a tick model
`timescale 1ns/10ps
module tb_top;
  localparam int FT = 20;
  localparam int B1 = dsr_pkg::COARSE_MAX * dsr_pkg::HALF_TICKS;
  localparam int B2 = 2 * B1;
  localparam int B3 = B2 + dsr_pkg::MID_MAX * dsr_pkg::HALF_TICKS;
  localparam int B4 = B3 + dsr_pkg::MID_MAX * dsr_pkg::HALF_TICKS;
  localparam int TE = B4 + FT;
  logic clk_i, rst_n_i, strobe_i, start_i, func_ac_i, load, cmp, route, dac_en, pos, busy, done;
  logic [4:0] ctrl, ce;
  logic [7:0] dac;
  logic signed [31:0] residual;
  dsr_pkg::dsr_counts_t cnts;
  logic [31:0] rnd = 32'h000043D2;
  logic [4:0] code [5] = '{dsr_pkg::CODE_M4, dsr_pkg::CODE_P4, dsr_pkg::CODE_M3, dsr_pkg::CODE_P2, dsr_pkg::CODE_M1};
  int errors, tests_run, cyc, nrun, t, per, act, crs, rc, rt, sg, first, be, de, pe, pend, fin, re, dm, nl, rl;
  int cnt [5];
  dsr_sequencer #(.FINE_TICKS(FT)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .strobe_i(strobe_i),
    .comparator_out_i(cmp), .start_i(start_i), .func_ac_i(func_ac_i), .ctrl_lines_o(ctrl),
    .input_route_o(route), .dac_en_o(dac_en), .dac_code_o(dac), .counts_o(cnts), .positive_o(pos),
    .busy_o(busy), .done_o(done));
  dsr_hybrid_model hyb_u (.strobe_i(strobe_i), .ctrl_lines_i(ctrl), .dac_en_i(dac_en),
    .dac_code_i(dac), .load_i(load), .residual_i(residual), .comparator_o(cmp));
  always #5 clk_i = ~clk_i;
  // cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // open a new current set at a period boundary
  task automatic sset(input int k, input logic c);
    per = k;
    ce = code[k];
    rc = c;
    crs = 0;
    rt = 0;
    act = 1;
    sg = 0;
    first = 1;
    rl = 0;
  endtask
  // reference sequencer, stepped once per tick with the latched comparator
  task automatic model(input logic c);
    int len;
    fin = 0;
    if (!be && pend) begin
      be = 1;
      de = 0;
      pend = 0;
      t = 0;
      pe = c;
      cnt = '{0, 0, 0, 0, 0};
      sset(0, c);
    end else if (be) begin
      t++;
      // a ramp that ends on a period boundary still counts and may still step the dac
      if (act) begin
        len = (per == 0 && pe) ? dsr_pkg::SHORT_TICKS : (per == 4 && sg) ? dsr_pkg::QUARTER_TICKS : dsr_pkg::HALF_TICKS;
        if (c != rc) crs = 1;
        rt++;
        rl++;
        if (rt == len) begin
          rt = 0;
          if (per == 4) begin
            if (!sg && first) cnt[4]++;
            if (crs) begin
              if (!sg) begin
                nl = rl;
                first = 0;
              end else if (nl > rl && dm != 255) begin
                dm++;
              end else if (nl < rl && dm != 0) begin
                dm--;
              end
              sg = !sg;
              rc = c;
              crs = 0;
              rl = 0;
              ce = sg ? dsr_pkg::CODE_P1 : dsr_pkg::CODE_M1;
            end
          end else begin
            cnt[per]++;
            if (crs || cnt[per] == (per < 2 ? dsr_pkg::COARSE_MAX : dsr_pkg::MID_MAX) || (per == 0 && pe)) begin
              act = 0;
              ce = dsr_pkg::CODE_M0;
            end
          end
        end
      end
      if (t == TE) begin
        be = 0;
        de = 1;
        fin = 1;
        ce = dsr_pkg::CODE_P0;
      end else if (t == B1 || t == B2 || t == B3 || t == B4) begin
        sset((t == B1) ? 1 : (t == B2) ? 2 : (t == B3) ? 3 : 4, c);
      end
    end
  endtask
  // one strobe period of ten clocks, compared just before the next strobe
  task automatic tick();
    @(posedge clk_i);
    strobe_i <= 1'b1;
    rnd = xs(rnd);
    func_ac_i <= rnd[0];
    re = rnd[0];
    repeat (5) @(posedge clk_i);
    strobe_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    model(cmp);
    chk(ctrl, ce);
    chk(busy, be);
    chk(done, de);
    chk(route, re);
    chk(dac, dm);
    if (be) chk(pos, pe);
    if (nrun == 0 && be) chk(dac_en, t >= B2);
    if (fin) chk(cnts, {cnt[0][2:0], cnt[1][2:0], cnt[2][2:0], cnt[3][2:0], cnt[4][7:0]});
  endtask
  task automatic go();
    @(posedge clk_i);
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    pend = 1;
  endtask
  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    strobe_i = 1'b0;
    start_i = 1'b0;
    func_ac_i = 1'b0;
    load = 1'b0;
    residual = 0;
    ce = dsr_pkg::CODE_P0;
    dm = dsr_pkg::DAC_MID;
    repeat (16) @(posedge clk_i);
    chk(ctrl, dsr_pkg::CODE_P0);
    chk(dac, dsr_pkg::DAC_MID);
    chk({busy, done, dac_en}, 3'h0);
    rst_n_i <= 1'b1;
    repeat (2) tick();
    // negative crossing, coarse limit, positive pulse, then random residuals
    for (int r = 0; r < 6; r++) begin
      rnd = xs(rnd);
      residual = (r == 0) ? -25000 : (r == 1) ? -50000 : (r == 2) ? 7000 : int'(rnd[15:0]) - 32768;
      @(posedge clk_i);
      load <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
      go();
      while (be || pend) begin
        tick();
        if (residual == 7000 && t == 100) begin
          residual = 0;
          go();
        end
      end
      nrun++;
      repeat (2) tick();
    end
    stop_test();
  end
endmodule // tb_top
